// file: rtl/chp_device.sv
// Purpose: Device end of the host port with LEDs and line pins
// Assumes: Host pins synchronous to REF_CLK_IN
// Notes: Register file is a plain scratch array; line logic is minimal
`timescale 1ns/1ps
`default_nettype none
`include "chp_params.svh"
// Operation
// - Polarity input selects active level of strobes
// - Strobes ignored while select inactive
// - Host waits 25 ns address setup
// - Host holds strobe at least 50 ns
// - Without busy-wait, host gaps 350 ns
// - Busy-wait high until done and strobe removed
// - Access-complete rises when access finished
// - Host starts next access after complete
// - 8-bit data buses, 4-bit address
// - All logic on one master clock
// - Reset returns all logic except the scratch registers to initial state
// - Host-access LED lit about 3 ms, retriggerable
// - Activity LED follows receive activity
// - Receive input is high-active line data
// - Two low-active dipulse outputs when transmitting
// - Low-active serial transmit data output
// - Transmitter enable low only while transmitting
// - Receive logic expects own transmission echoed
module chp_device #(
   parameter int LED_HOLD_CYC = `CHP_LED_HOLD_CYC,
   parameter int ACT_HOLD_CYC = `CHP_ACT_HOLD_CYC
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic CLK_EN_IN,
   chp_if.dev HOST,
   input wire logic RX_DATA_IN,
   input wire logic TX_START_IN,
   input wire logic [`CHP_DATA_W-1:0] TX_BYTE_IN,
   input wire logic IRQ_ENABLE_IN,
   output logic INTERRUPT_OUT,
   output logic LED_HOST_N_OUT,
   output logic LED_ACT_N_OUT,
   output logic DIPULSE_A_N_OUT,
   output logic DIPULSE_B_N_OUT,
   output logic TX_DATA_N_OUT,
   output logic TX_ENABLE_N_OUT,
   output logic ECHO_ERROR_OUT
);
   import chp_pkg::*;

   // ==========================================================
   // Host strobe decode
   logic cs_act, rd_act, wr_act, req;
   always_comb begin
      cs_act = HOST.cs ~^ HOST.polarity;
      rd_act = HOST.rd ~^ HOST.polarity;
      wr_act = HOST.wr ~^ HOST.polarity;
      req = cs_act & (rd_act | wr_act);
   end

   // ==========================================================
   // Access engine
   chp_dev_state_t state_r, state_nxt;
   logic [2:0] lat_r, lat_nxt;
   logic [`CHP_DATA_W-1:0] regs_r [`CHP_NUM_REGS];
   logic [`CHP_DATA_W-1:0] rdata_r, rdata_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, wr_pulse, irq_r, irq_nxt;
   logic [`CHP_ADDR_W-1:0] addr_r, addr_nxt;
   logic [`CHP_DATA_W-1:0] wdata_r, wdata_nxt;
   logic is_wr_r, is_wr_nxt;

   always_comb begin
      state_nxt = state_r;
      lat_nxt = lat_r;
      rdata_nxt = rdata_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      is_wr_nxt = is_wr_r;
      wr_pulse = 1'b0;
      irq_nxt = irq_r;
      case (state_r)
         CHP_DEV_IDLE: begin
            if (req) begin
               // Latch once; host keeps address stable through the strobe
               addr_nxt = HOST.addr;
               wdata_nxt = HOST.data_to_dev;
               is_wr_nxt = wr_act;
               lat_nxt = 3'(`CHP_ACCESS_LAT_CYC - 1);
               busy_nxt = 1'b1;
               state_nxt = CHP_DEV_BUSY;
            end
         end
         CHP_DEV_BUSY: begin
            if (lat_r == 3'h0) begin
               wr_pulse = is_wr_r;
               rdata_nxt = regs_r[addr_r];
               done_nxt = 1'b1;
               if (is_wr_r && addr_r == 4'hF) begin
                  irq_nxt = wdata_r[0];
               end
               state_nxt = CHP_DEV_DONE;
            end else begin
               lat_nxt = lat_r - 3'h1;
            end
         end
         CHP_DEV_DONE: begin
            if (!req) begin
               done_nxt = 1'b0;
               busy_nxt = 1'b0;
               state_nxt = CHP_DEV_IDLE;
            end
         end
         default: begin
            state_nxt = CHP_DEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state_r <= CHP_DEV_IDLE;
         lat_r <= 3'h0;
         rdata_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         addr_r <= 4'h0;
         wdata_r <= 8'h00;
         is_wr_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (CLK_EN_IN) begin
         state_r <= state_nxt;
         lat_r <= lat_nxt;
         rdata_r <= rdata_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         is_wr_r <= is_wr_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Scratch registers; no reset so the array maps to memory
   always_ff @(posedge REF_CLK_IN) begin
      if (CLK_EN_IN && wr_pulse) begin
         regs_r[addr_r] <= wdata_r;
      end
   end

   assign HOST.data_from_dev = rdata_r;
   assign HOST.busy_wait = busy_r;
   assign HOST.access_done = done_r;

   // ==========================================================
   // Transmit serialiser and echo check
   logic [`CHP_DATA_W-1:0] sh_r, sh_nxt;
   logic [3:0] bits_r, bits_nxt;
   logic [2:0] ph_r, ph_nxt;
   logic txing_r, txing_nxt, pa_nxt, pb_nxt, txd_nxt;
   logic rx_d_r, echo_err_r, echo_err_nxt;
   always_comb begin
      sh_nxt = sh_r;
      bits_nxt = bits_r;
      ph_nxt = ph_r;
      txing_nxt = txing_r;
      echo_err_nxt = echo_err_r;
      if (!txing_r) begin
         if (TX_START_IN) begin
            sh_nxt = TX_BYTE_IN;
            bits_nxt = 4'h8;
            ph_nxt = 3'h0;
            txing_nxt = 1'b1;
            echo_err_nxt = 1'b0;
         end
      end else begin
         ph_nxt = ph_r + 3'h1;
         // Sampled inside the pulse half, so a one-bit echo is still present
         if (ph_r == 3'h3 && rx_d_r != sh_r[0]) begin
            echo_err_nxt = 1'b1;
         end
         if (ph_r == 3'h7) begin
            sh_nxt = {1'b0, sh_r[`CHP_DATA_W-1:1]};
            bits_nxt = bits_r - 4'h1;
            if (bits_r == 4'h1) begin
               txing_nxt = 1'b0;
            end
         end
      end
      // Dipulse: one pulse per one-bit, A in the first quarter of the bit, B in the second quarter
      pa_nxt = !(txing_nxt && sh_nxt[0] && ph_nxt < 3'h2);
      pb_nxt = !(txing_nxt && sh_nxt[0] && ph_nxt >= 3'h2 && ph_nxt < 3'h4);
      txd_nxt = !(txing_nxt && sh_nxt[0] && ph_nxt < 3'h4);
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         sh_r <= 8'h00;
         bits_r <= 4'h0;
         ph_r <= 3'h0;
         txing_r <= 1'b0;
         rx_d_r <= 1'b0;
         echo_err_r <= 1'b0;
      end else if (CLK_EN_IN) begin
         sh_r <= sh_nxt;
         bits_r <= bits_nxt;
         ph_r <= ph_nxt;
         txing_r <= txing_nxt;
         rx_d_r <= RX_DATA_IN;
         echo_err_r <= echo_err_nxt;
      end
   end

   // ==========================================================
   // LEDs and interrupt
   logic [31:0] led_cnt_r, led_cnt_nxt, act_cnt_r, act_cnt_nxt;
   always_comb begin
      led_cnt_nxt = led_cnt_r;
      if (state_r == CHP_DEV_IDLE && req) begin
         led_cnt_nxt = 32'(LED_HOLD_CYC);
      end else if (led_cnt_r != 32'h0) begin
         led_cnt_nxt = led_cnt_r - 32'h1;
      end
      act_cnt_nxt = act_cnt_r;
      if (rx_d_r) begin
         act_cnt_nxt = 32'(ACT_HOLD_CYC);
      end else if (act_cnt_r != 32'h0) begin
         act_cnt_nxt = act_cnt_r - 32'h1;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         led_cnt_r <= 32'h0;
         act_cnt_r <= 32'h0;
         LED_HOST_N_OUT <= 1'b1;
         LED_ACT_N_OUT <= 1'b1;
         INTERRUPT_OUT <= 1'b0;
         DIPULSE_A_N_OUT <= 1'b1;
         DIPULSE_B_N_OUT <= 1'b1;
         TX_DATA_N_OUT <= 1'b1;
         TX_ENABLE_N_OUT <= 1'b1;
         ECHO_ERROR_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         led_cnt_r <= led_cnt_nxt;
         act_cnt_r <= act_cnt_nxt;
         LED_HOST_N_OUT <= (led_cnt_nxt == 32'h0);
         LED_ACT_N_OUT <= (act_cnt_nxt == 32'h0);
         INTERRUPT_OUT <= irq_nxt & IRQ_ENABLE_IN;
         DIPULSE_A_N_OUT <= pa_nxt;
         DIPULSE_B_N_OUT <= pb_nxt;
         TX_DATA_N_OUT <= txd_nxt;
         TX_ENABLE_N_OUT <= !txing_nxt;
         ECHO_ERROR_OUT <= echo_err_nxt;
      end
   end
endmodule
`default_nettype wire

// file: rtl/chp_params.svh
// Purpose: Constants for the parallel host port and line pins
// Assumes: 125 MHz reference clock
// Notes: Times in ns, counts derived from the clock period
`ifndef CHP_PARAMS_SVH
`define CHP_PARAMS_SVH
`define CHP_CLK_PERIOD_NS 8
`define CHP_ADDR_SETUP_NS 25
`define CHP_STROBE_MIN_NS 50
`define CHP_ACCESS_GAP_NS 350
`define CHP_LED_HOLD_NS 3000000
`define CHP_ADDR_SETUP_CYC ((`CHP_ADDR_SETUP_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
`define CHP_STROBE_MIN_CYC ((`CHP_STROBE_MIN_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
`define CHP_ACCESS_GAP_CYC ((`CHP_ACCESS_GAP_NS + `CHP_CLK_PERIOD_NS - 1) / `CHP_CLK_PERIOD_NS)
`define CHP_LED_HOLD_CYC (`CHP_LED_HOLD_NS / `CHP_CLK_PERIOD_NS)
`define CHP_ACCESS_LAT_CYC 4
`define CHP_ACT_HOLD_CYC 1024
`define CHP_ADDR_W 4
`define CHP_DATA_W 8
`define CHP_NUM_REGS 16
`define CHP_TX_BIT_CYC 8
`endif

// file: rtl/chp_pkg.sv
// Purpose: Types shared by both ends of the host port
// Assumes: Constants come from chp_params.svh
// Notes: One-hot state codes
package chp_pkg;
   typedef enum logic [3:0] {
      CHP_DEV_IDLE = 4'h1,
      CHP_DEV_BUSY = 4'h2,
      CHP_DEV_DONE = 4'h4,
      CHP_DEV_GAP = 4'h8
   } chp_dev_state_t;
   typedef enum logic [4:0] {
      CHP_HST_IDLE = 5'h01,
      CHP_HST_SETUP = 5'h02,
      CHP_HST_STROBE = 5'h04,
      CHP_HST_RELEASE = 5'h08,
      CHP_HST_GAP = 5'h10
   } chp_hst_state_t;
endpackage

// file: rtl/chp_if.sv
// Purpose: Pin bundle between host and device ends
// Assumes: Single clock, polarity selected by the host side
// Notes: Strobes carry the polarity on the wire
`timescale 1ns/1ps
`default_nettype none
`include "chp_params.svh"
interface chp_if;
   logic polarity;
   logic cs;
   logic rd;
   logic wr;
   logic [`CHP_ADDR_W-1:0] addr;
   logic [`CHP_DATA_W-1:0] data_to_dev;
   logic [`CHP_DATA_W-1:0] data_from_dev;
   logic busy_wait;
   logic access_done;
   modport dev (
      input polarity, cs, rd, wr, addr, data_to_dev,
      output data_from_dev, busy_wait, access_done
   );
   modport hst (
      output polarity, cs, rd, wr, addr, data_to_dev,
      input data_from_dev, busy_wait, access_done
   );
endinterface
`default_nettype wire

// file: rtl/chp_host.sv
// Purpose: Host end driving the strobe port
// Assumes: Device pins synchronous to REF_CLK_IN
// Notes: One access at a time from a user request
`timescale 1ns/1ps
`default_nettype none
`include "chp_params.svh"
module chp_host #(
   parameter int USE_BUSY_WAIT = 1
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic CLK_EN_IN,
   chp_if.hst PORT,
   input wire logic POLARITY_IN,
   input wire logic REQ_IN,
   input wire logic REQ_WRITE_IN,
   input wire logic [`CHP_ADDR_W-1:0] REQ_ADDR_IN,
   input wire logic [`CHP_DATA_W-1:0] REQ_WDATA_IN,
   output logic REQ_READY_OUT,
   output logic RESP_VALID_OUT,
   output logic [`CHP_DATA_W-1:0] RESP_RDATA_OUT
);
   import chp_pkg::*;

   // ==========================================================
   // Access sequencer
   chp_hst_state_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic cs_r, cs_nxt, rd_r, rd_nxt, wr_r, wr_nxt, pol_r;
   logic [`CHP_ADDR_W-1:0] addr_r, addr_nxt;
   logic [`CHP_DATA_W-1:0] wd_r, wd_nxt, rdat_nxt;
   logic rv_nxt, rdy_nxt;
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cs_nxt = cs_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      wd_nxt = wd_r;
      rdat_nxt = RESP_RDATA_OUT;
      rv_nxt = 1'b0;
      rdy_nxt = 1'b0;
      case (state_r)
         CHP_HST_IDLE: begin
            rdy_nxt = 1'b1;
            if (REQ_IN) begin
               cs_nxt = 1'b1;
               addr_nxt = REQ_ADDR_IN;
               wd_nxt = REQ_WDATA_IN;
               wr_nxt = 1'b0;
               rd_nxt = 1'b0;
               cnt_nxt = 8'(`CHP_ADDR_SETUP_CYC);
               rdy_nxt = 1'b0;
               state_nxt = CHP_HST_SETUP;
            end
            wr_nxt = wr_nxt | (REQ_IN & REQ_WRITE_IN & 1'b0);
         end
         CHP_HST_SETUP: begin
            if (cnt_r <= 8'h1) begin
               wr_nxt = REQ_WRITE_IN;
               rd_nxt = !REQ_WRITE_IN;
               cnt_nxt = 8'(`CHP_STROBE_MIN_CYC);
               state_nxt = CHP_HST_STROBE;
            end else begin
               cnt_nxt = cnt_r - 8'h1;
            end
         end
         CHP_HST_STROBE: begin
            if (cnt_r > 8'h1) begin
               cnt_nxt = cnt_r - 8'h1;
            end
            if (cnt_r <= 8'h1 && (PORT.access_done || USE_BUSY_WAIT == 0)) begin
               rdat_nxt = PORT.data_from_dev;
               rv_nxt = rd_r;
               rd_nxt = 1'b0;
               wr_nxt = 1'b0;
               cs_nxt = 1'b0;
               cnt_nxt = 8'(`CHP_ACCESS_GAP_CYC);
               state_nxt = USE_BUSY_WAIT != 0 ? CHP_HST_RELEASE : CHP_HST_GAP;
            end
         end
         CHP_HST_RELEASE: begin
            if (!PORT.busy_wait) begin
               state_nxt = CHP_HST_IDLE;
            end
         end
         CHP_HST_GAP: begin
            if (cnt_r <= 8'h1) begin
               state_nxt = CHP_HST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 8'h1;
            end
         end
         default: begin
            state_nxt = CHP_HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state_r <= CHP_HST_IDLE;
         cnt_r <= 8'h00;
         cs_r <= 1'b0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         addr_r <= 4'h0;
         wd_r <= 8'h00;
         pol_r <= 1'b0;
         REQ_READY_OUT <= 1'b0;
         RESP_VALID_OUT <= 1'b0;
         RESP_RDATA_OUT <= 8'h00;
      end else if (CLK_EN_IN) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cs_r <= cs_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         wd_r <= wd_nxt;
         // Polarity only changes while idle to avoid phantom strobes
         if (state_r == CHP_HST_IDLE) begin
            pol_r <= POLARITY_IN;
         end
         REQ_READY_OUT <= rdy_nxt;
         RESP_VALID_OUT <= rv_nxt;
         RESP_RDATA_OUT <= rdat_nxt;
      end
   end

   // Wire levels follow polarity select
   assign PORT.polarity = pol_r;
   assign PORT.cs = cs_r ~^ pol_r;
   assign PORT.rd = rd_r ~^ pol_r;
   assign PORT.wr = wr_r ~^ pol_r;
   assign PORT.addr = addr_r;
   assign PORT.data_to_dev = wd_r;
endmodule
`default_nettype wire

// file: tb/chp_monitor.sv
// Purpose: Assertions on the host port wires between host and device
// Assumes: One clock, asynchronous active-high reset
// Notes: Watches the first pair only
`timescale 1ns/1ps
`default_nettype none
`include "chp_params.svh"
module chp_monitor (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic polarity,
   input wire logic cs,
   input wire logic rd,
   input wire logic wr,
   input wire logic [`CHP_ADDR_W-1:0] addr,
   input wire logic [`CHP_DATA_W-1:0] data_to_dev,
   input wire logic [`CHP_DATA_W-1:0] data_from_dev,
   input wire logic busy_wait,
   input wire logic access_done
);
   // ==========
   // Handshake checks
   logic req;
   // Active level follows the polarity wire
   assign req = cs == polarity && (rd == polarity || wr == polarity);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);
   take_busy_a: assert property ($rose(req) && !busy_wait |=> busy_wait)
      else $error("busy not raised after strobe");
   no_take_a: assert property (!busy_wait && !access_done && !req |=> !busy_wait)
      else $error("busy raised without selected strobe");
   done_lat_a: assert property ($rose(busy_wait) |-> !access_done [*4] ##1 access_done)
      else $error("access complete not four cycles after busy");
   busy_hold_a: assert property (access_done && req |=> busy_wait && access_done)
      else $error("handshake dropped while strobe held");
   drop_both_a: assert property (access_done && !req |=> !busy_wait && !access_done)
      else $error("handshake not dropped after release");
   done_busy_a: assert property (access_done |-> busy_wait)
      else $error("complete without busy");
   data_hold_a: assert property (!$rose(access_done) |-> $stable(data_from_dev))
      else $error("read data changed outside completion");
   // First edge in reset skipped: the flops may still be unknown at that sample
   reset_idle_a: assert property (@(posedge REF_CLK_IN) disable iff (1'b0)
      RESET_IN && $past(RESET_IN) |-> !busy_wait && !access_done && data_from_dev == 8'h00)
      else $error("outputs not idle in reset");
   cover property (req && polarity && access_done);
   cover property (req && !polarity && access_done);
   cover property ($rose(access_done) && addr == 4'hF && data_to_dev[0]);
endmodule
`default_nettype wire

// file: tb/classic_host_port_and_line_pins_tb.sv
// Purpose: Self-checking bench for both ends of the host port and line pins
// Assumes: LED and activity holds shortened through parameters
// Notes: Second device is driven by the bench to break host rules
`timescale 1ns/1ps
`default_nettype none
`include "chp_params.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module classic_host_port_and_line_pins_tb;
   // ==========
   // Signals and instances
   localparam int LED_HOLD = 80;
   logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, pol = 1'b0, req = 1'b0, req_wr = 1'b0;
   logic [3:0] req_addr = 4'h0, addr_q = 4'h0;
   logic [7:0] req_wdata = 8'h00, tx_byte = 8'h00, resp_rdata, bw_rdata;
   logic bw_valid;
   logic tx_start = 1'b0, irq_en = 1'b0, loop_on = 1'b1, rx, stb, stb_q = 1'b0, seen_done;
   logic ready, resp_valid, irq, led_host_n, led_act_n, pa_n, pb_n, txd_n, txen_n, echo_err;
   logic [15:0] r;
   int miscompares = 0, checks_done = 0, cycles = 0, seed = 44821, pend = 0, i;
   int setup_n = 0, width_n = 0, gap_n = 100, last_acc = -1000;
   int mem [16];
   int exp_q [$];
   int exp_b [$];
   chp_if link_if ();
   chp_if side_if ();
   chp_if bw_if ();
   always #4 clk = ~clk;
   // Feedback loop from transmit to receive, inverted when broken on purpose
   assign rx = loop_on ? ~txd_n : txd_n;
   assign stb = link_if.cs == link_if.polarity &&
      (link_if.rd == link_if.polarity || link_if.wr == link_if.polarity);
   chp_host #(.USE_BUSY_WAIT(0)) chp_host_inst (.REF_CLK_IN(clk), .RESET_IN(rst),
      .CLK_EN_IN(clk_en), .PORT(link_if.hst), .POLARITY_IN(pol), .REQ_IN(req),
      .REQ_WRITE_IN(req_wr), .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata),
      .REQ_READY_OUT(ready), .RESP_VALID_OUT(resp_valid), .RESP_RDATA_OUT(resp_rdata));
   chp_device #(.LED_HOLD_CYC(LED_HOLD), .ACT_HOLD_CYC(8)) chp_device_inst (
      .REF_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en), .HOST(link_if.dev),
      .RX_DATA_IN(rx), .TX_START_IN(tx_start), .TX_BYTE_IN(tx_byte),
      .IRQ_ENABLE_IN(irq_en), .INTERRUPT_OUT(irq), .LED_HOST_N_OUT(led_host_n),
      .LED_ACT_N_OUT(led_act_n), .DIPULSE_A_N_OUT(pa_n), .DIPULSE_B_N_OUT(pb_n),
      .TX_DATA_N_OUT(txd_n), .TX_ENABLE_N_OUT(txen_n), .ECHO_ERROR_OUT(echo_err));
   chp_device #(.LED_HOLD_CYC(LED_HOLD), .ACT_HOLD_CYC(8)) chp_device_inst_b (
      .REF_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en), .HOST(side_if.dev),
      .RX_DATA_IN(rx), .TX_START_IN(tx_start), .TX_BYTE_IN(tx_byte),
      .IRQ_ENABLE_IN(irq_en), .INTERRUPT_OUT(), .LED_HOST_N_OUT(), .LED_ACT_N_OUT(),
      .DIPULSE_A_N_OUT(), .DIPULSE_B_N_OUT(), .TX_DATA_N_OUT(), .TX_ENABLE_N_OUT(),
      .ECHO_ERROR_OUT());
   // Busy-wait pair takes every request beside the main pair
   chp_host #(.USE_BUSY_WAIT(1)) chp_host_inst_b (.REF_CLK_IN(clk), .RESET_IN(rst),
      .CLK_EN_IN(clk_en), .PORT(bw_if.hst), .POLARITY_IN(pol), .REQ_IN(req),
      .REQ_WRITE_IN(req_wr), .REQ_ADDR_IN(req_addr), .REQ_WDATA_IN(req_wdata),
      .REQ_READY_OUT(), .RESP_VALID_OUT(bw_valid), .RESP_RDATA_OUT(bw_rdata));
   chp_device #(.LED_HOLD_CYC(LED_HOLD), .ACT_HOLD_CYC(8)) chp_device_inst_c (
      .REF_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en), .HOST(bw_if.dev),
      .RX_DATA_IN(rx), .TX_START_IN(tx_start), .TX_BYTE_IN(tx_byte),
      .IRQ_ENABLE_IN(irq_en), .INTERRUPT_OUT(), .LED_HOST_N_OUT(), .LED_ACT_N_OUT(),
      .DIPULSE_A_N_OUT(), .DIPULSE_B_N_OUT(), .TX_DATA_N_OUT(), .TX_ENABLE_N_OUT(),
      .ECHO_ERROR_OUT());
   chp_monitor chp_monitor_inst (.REF_CLK_IN(clk), .RESET_IN(rst),
      .polarity(link_if.polarity), .cs(link_if.cs), .rd(link_if.rd), .wr(link_if.wr),
      .addr(link_if.addr), .data_to_dev(link_if.data_to_dev),
      .data_from_dev(link_if.data_from_dev), .busy_wait(link_if.busy_wait),
      .access_done(link_if.access_done));
   // ==========
   // Wire timing, LED and read data watch
   always @(negedge clk) begin
      setup_n = (link_if.addr === addr_q) ? setup_n + 1 : 0;
      addr_q = link_if.addr;
      if (rst) begin
         gap_n = 100;
         last_acc = -1000;
         stb_q = 1'b0;
      end else begin
         if (stb && !stb_q) begin
            `CHK("setup", 1'b1, setup_n >= `CHP_ADDR_SETUP_CYC)
            `CHK("gap", 1'b1, gap_n >= `CHP_ACCESS_GAP_CYC)
            width_n = 0;
            seen_done = 1'b0;
            last_acc = cycles;
         end
         if (!stb && stb_q) begin
            `CHK("width", 1'b1, width_n >= `CHP_STROBE_MIN_CYC)
            `CHK("done_seen", 1'b1, seen_done)
            gap_n = 0;
         end
         width_n++;
         gap_n++;
         seen_done = seen_done | link_if.access_done;
         stb_q = stb;
         // Lit shortly after each strobe, dark well after the hold
         if (cycles - last_acc > 3 && cycles - last_acc < LED_HOLD - 5)
            `CHK("led_on", 1'b0, led_host_n)
         if (cycles - last_acc > LED_HOLD + 10) `CHK("led_off", 1'b1, led_host_n)
         if (resp_valid === 1'b1) begin
            `CHK("resp", 1'b1, exp_q.size() > 0)
            if (exp_q.size() > 0) `CHK("rdata", exp_q.pop_front(), resp_rdata)
         end
         if (bw_valid === 1'b1) begin
            `CHK("resp_bw", 1'b1, exp_b.size() > 0)
            if (exp_b.size() > 0) `CHK("rdata_bw", exp_b.pop_front(), bw_rdata)
         end
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ==========
   // Tasks and main sequence
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic host_op(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic p, input logic e);
      while (ready !== 1'b1) @(negedge clk);
      `CHK("irq", pend & irq_en, irq)
      pol = p;
      irq_en = e;
      req = 1'b1;
      req_wr = w;
      req_addr = a;
      req_wdata = d;
      if (w && a == 4'hF) pend = d[0];
      if (w) mem[a] = d;
      else begin
         exp_q.push_back(mem[a]);
         exp_b.push_back(mem[a]);
      end
      @(negedge clk);
      req = 1'b0;
   endtask
   task automatic side_op(input logic p);
      int n;
      side_if.polarity = p;
      side_if.cs = ~p;
      side_if.rd = p;
      side_if.wr = ~p;
      repeat (6) begin
         @(negedge clk);
         `CHK("no_select", 1'b0, side_if.busy_wait)
      end
      side_if.cs = p;
      @(negedge clk);
      `CHK("busy", 1'b1, side_if.busy_wait)
      n = 1;
      while (side_if.access_done !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      `CHK("latency", 5, n)
      repeat (3) @(negedge clk);
      `CHK("stand", 2'b11, {side_if.busy_wait, side_if.access_done})
      // Strobe removed while frozen: handshake must hold until enabled again
      clk_en = 1'b0;
      side_if.rd = ~p;
      repeat (3) @(negedge clk);
      `CHK("frozen", 2'b11, {side_if.busy_wait, side_if.access_done})
      clk_en = 1'b1;
      @(negedge clk);
      `CHK("drop", 2'b00, {side_if.busy_wait, side_if.access_done})
      side_if.cs = ~p;
      repeat (4) @(negedge clk);
   endtask
   task automatic line_frame(input logic [7:0] b);
      int j;
      logic act;
      logic [3:0] ex;
      act = 1'b0;
      tx_byte = b;
      tx_start = 1'b1;
      @(negedge clk);
      tx_start = 1'b0;
      for (j = 0; j < 4 && txen_n !== 1'b0; j++) @(negedge clk);
      // Bits leave least significant first, eight cycles each
      for (j = 0; j < 64; j++) begin
         ex = {1'b0, ~(b[j/8] && j%8 < 2), ~(b[j/8] && j%8 > 1 && j%8 < 4), ~(b[j/8] && j%8 < 4)};
         `CHK("line", ex, {txen_n, pa_n, pb_n, txd_n})
         act = act | ~led_act_n;
         @(negedge clk);
      end
      `CHK("activity", 1'b1, act)
      `CHK("tx_end", 1'b1, txen_n)
   endtask
   initial begin
      side_if.polarity = 1'b0;
      side_if.cs = 1'b1;
      side_if.rd = 1'b1;
      side_if.wr = 1'b1;
      side_if.addr = 4'h0;
      side_if.data_to_dev = 8'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      side_op(1'b0);
      side_op(1'b1);
      // Scratch bytes have no reset, so fill them before any read
      for (i = 0; i < 16; i++) host_op(1'b1, i[3:0], 8'(i * 37 + 5), 1'b0, 1'b0);
      repeat (40) begin
         r = 16'($random(seed));
         host_op(r[0], r[4:1], r[12:5], r[13], r[14]);
      end
      host_op(1'b1, 4'hF, 8'h01, 1'b0, 1'b1);
      host_op(1'b0, 4'hF, 8'h00, 1'b0, 1'b1);
      while (ready !== 1'b1) @(negedge clk);
      repeat (100) @(negedge clk);
      rst = 1'b1;
      pend = 0;
      repeat (2) @(negedge clk);
      `CHK("reset", 3'b011, {irq, led_host_n, txen_n})
      rst = 1'b0;
      host_op(1'b0, 4'h3, 8'h00, 1'b0, 1'b1);
      line_frame(8'hA5);
      `CHK("echo_ok", 1'b0, echo_err)
      repeat (20) @(negedge clk);
      `CHK("act_idle", 1'b1, led_act_n)
      loop_on = 1'b0;
      line_frame(8'h5A);
      `CHK("echo_bad", 1'b1, echo_err)
      host_op(1'b0, 4'h7, 8'h00, 1'b0, 1'b0);
      while (ready !== 1'b1) @(negedge clk);
      `CHK("pending", 0, exp_q.size())
      `CHK("pending_bw", 0, exp_b.size())
      give_verdict();
   end
endmodule
`default_nettype wire
